// [rtl/dcp_chan_if.sv]
`timescale 1ns/1ps
interface dcp_chan_if;
  logic [31:0] high_time;
  logic [15:0] control;
  logic ctrl_wr;
  logic level;
  logic drive_en;
  logic running;
  logic stage_hs;

  modport top (output high_time, output control, output ctrl_wr,
               input level, input drive_en, input running, input stage_hs);
  modport chan (input high_time, input control, input ctrl_wr,
                output level, output drive_en, output running, output stage_hs);
endinterface

// [rtl/dcp_channel.sv]
`timescale 1ns/1ps
module dcp_channel #(
  parameter int unsigned PERIOD_TICKS = dcp_pkg::PERIOD_TICKS_DEF
) (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic clk_en, // Freezes state while low
  dcp_chan_if.chan ch // Channel image and output
);

  localparam logic [31:0] PERIOD_SCALED = 32'(PERIOD_TICKS * dcp_pkg::TICK_SCALE);
  localparam logic [31:0] STEP = 32'(dcp_pkg::TICK_STEP);

  logic run_ff, nxt_run;
  logic stage_ff, nxt_stage;
  logic start_prev_ff, nxt_start_prev;
  logic stop_prev_ff, nxt_stop_prev;
  logic [31:0] elapsed_ff, nxt_elapsed;
  logic level_ff, nxt_level;
  logic [31:0] high_scaled;
  logic [31:0] step_sum;
  logic start_edge, stop_edge;

  always_comb
  begin
    high_scaled = 32'(ch.high_time * dcp_pkg::TICK_SCALE);
    step_sum = elapsed_ff + STEP;
    start_edge = ch.ctrl_wr && ch.control[dcp_pkg::CTRL_START_BIT] && !start_prev_ff;
    stop_edge = ch.ctrl_wr && ch.control[dcp_pkg::CTRL_STOP_BIT] && !stop_prev_ff;
    nxt_start_prev = ch.ctrl_wr ? ch.control[dcp_pkg::CTRL_START_BIT] : start_prev_ff;
    nxt_stop_prev = ch.ctrl_wr ? ch.control[dcp_pkg::CTRL_STOP_BIT] : stop_prev_ff;
    nxt_stage = ch.ctrl_wr ? ch.control[dcp_pkg::CTRL_STAGE_BIT] : stage_ff;
    nxt_run = run_ff;
    nxt_elapsed = elapsed_ff;
    // Stop wins over a start in the same write: the safe outcome is a quiet output
    if (stop_edge)
    begin
      nxt_run = 1'b0;
    end
    else if (start_edge && !run_ff)
    begin
      nxt_run = 1'b1;
      nxt_elapsed = 32'h0000_0000;
    end
    if (run_ff && !stop_edge)
    begin
      if (step_sum >= PERIOD_SCALED)
      begin
        nxt_elapsed = step_sum - PERIOD_SCALED;
      end
      else
      begin
        nxt_elapsed = step_sum;
      end
    end
    // High first in every period, low for the remainder
    nxt_level = nxt_run && (nxt_elapsed < high_scaled);
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_ff <= 1'b0;
      stage_ff <= 1'b0;
      start_prev_ff <= 1'b0;
      stop_prev_ff <= 1'b0;
      elapsed_ff <= 32'h0000_0000;
      level_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      run_ff <= nxt_run;
      stage_ff <= nxt_stage;
      start_prev_ff <= nxt_start_prev;
      stop_prev_ff <= nxt_stop_prev;
      elapsed_ff <= nxt_elapsed;
      level_ff <= nxt_level;
    end
  end

  assign ch.level = level_ff;
  // High-side stage lets go of the pin instead of pulling low
  assign ch.drive_en = stage_ff ? level_ff : 1'b1;
  assign ch.running = run_ff;
  assign ch.stage_hs = stage_ff;

endmodule

// [rtl/dcp_pkg.sv]
package dcp_pkg;

  localparam int unsigned NUM_CH = 2;

  // Output area byte offsets
  localparam logic [3:0] OUT_CH0_HIGH_TIME = 4'h0;
  localparam logic [3:0] OUT_CH1_HIGH_TIME = 4'h4;
  localparam logic [3:0] OUT_CH0_CONTROL = 4'h8;
  localparam logic [3:0] OUT_CH1_CONTROL = 4'ha;
  localparam logic [3:0] OUT_AREA_BYTES = 4'hc;

  // Input area byte offsets
  localparam logic [1:0] IN_CH0_STATUS = 2'h0;
  localparam logic [1:0] IN_CH1_STATUS = 2'h2;

  // Control word fields
  localparam int unsigned CTRL_STAGE_BIT = 2;
  localparam int unsigned CTRL_START_BIT = 8;
  localparam int unsigned CTRL_STOP_BIT = 9;

  // Status word fields
  localparam int unsigned STS_RUN_BIT = 1;
  localparam int unsigned STS_STAGE_BIT = 2;

  // Reset values
  localparam logic [7:0] IMG_BYTE_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // Time base: one tick is 1/48 MHz (20.83 ns), ref_clk is 40 MHz
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_HZ = 48_000_000;
  localparam int unsigned RATE_GCD_HZ = 8_000_000;
  // Elapsed time kept in units of 1/TICK_SCALE tick; each clock adds TICK_STEP
  localparam int unsigned TICK_STEP = TICK_HZ / RATE_GCD_HZ;
  localparam int unsigned TICK_SCALE = CLK_HZ / RATE_GCD_HZ;

  localparam int unsigned HIGH_TIME_MIN = 48;
  localparam int unsigned HIGH_TIME_MAX = 8388607;
  // Period in ticks (1 ms); configured outside the output area
  localparam int unsigned PERIOD_TICKS_DEF = 48000;

endpackage

// [rtl/dcp_pwm.sv]
// Function
// - Two independent channels each emit a repeating pulse train per their timing.
// - Status word per channel at input +0/+2; bit 1 shows running.
// - Output stage push-pull or high-side; status bit 2 shows high-side.
// - Output area: high times at +0/+4, control words at +8/+10.
// - Channel indicator follows output level when bus is up and no fault.
// - Fault indicator lights on overload, short or overheat regardless of bus communication.
// - Run indicator lit while bus communication works, dark otherwise.
// - Bus power failure keeps run and fault indicators dark.
// - Rising edge of control bit 8 starts, bit 9 stops; levels ignored.
// - Control bit 2 selects stage: 0 drives both levels, 1 only high.
`timescale 1ns/1ps
module dcp_pwm #(
  parameter int unsigned PERIOD_TICKS = dcp_pkg::PERIOD_TICKS_DEF
) (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic clk_en, // Clock enable, state frozen when low
  input wire logic out_wr, // Output area byte write strobe
  input wire logic [3:0] out_addr, // Output area byte address
  input wire logic [7:0] out_wdata, // Output area write byte
  input wire logic [1:0] in_addr, // Input area byte address
  output logic [7:0] in_rdata, // Input area read byte, one cycle after address
  input wire logic bus_comm_ok, // Backplane communication running
  input wire logic bus_power_ok, // Backplane power present
  input wire logic overload_det, // Output overload detected
  input wire logic short_det, // Output short circuit detected
  input wire logic overheat_det, // Overheat detected
  output logic [1:0] pwm_out, // Modulated output level per channel
  output logic [1:0] pwm_oe, // Output enable per channel
  output logic [1:0] chan_led, // Green channel indicators
  output logic run_led, // Green run indicator
  output logic module_fault_indicator // Red module-fault indicator
);

  localparam int unsigned IMG_BYTES = int'(dcp_pkg::OUT_AREA_BYTES);

  logic [7:0] img_ff [IMG_BYTES];
  logic [7:0] nxt_img [IMG_BYTES];
  logic [1:0] ctrl_wr_ff, nxt_ctrl_wr;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [15:0] sts_word [dcp_pkg::NUM_CH];
  logic [1:0] led_ff, nxt_led;
  logic run_led_ff, nxt_run_led;
  logic fault_led_ff, nxt_fault_led;
  logic any_fault;
  logic [31:0] ht_ff [dcp_pkg::NUM_CH];
  logic [31:0] nxt_ht [dcp_pkg::NUM_CH];
  logic [dcp_pkg::NUM_CH-1:0] ch_running;
  logic [dcp_pkg::NUM_CH-1:0] ch_stage_hs;

  dcp_chan_if ch_if [dcp_pkg::NUM_CH] ();

  // Byte-wide process image; writes beyond the 12-byte area are dropped
  always_comb
  begin
    for (int i = 0; i < IMG_BYTES; i++)
    begin
      nxt_img[i] = img_ff[i];
    end
    nxt_ctrl_wr = 2'h0;
    if (out_wr && (out_addr < dcp_pkg::OUT_AREA_BYTES))
    begin
      nxt_img[out_addr] = out_wdata;
      // The start/stop bits live in the upper control byte
      if (out_addr == dcp_pkg::OUT_CH0_CONTROL + 4'h1)
      begin
        nxt_ctrl_wr[0] = 1'b1;
      end
      if (out_addr == dcp_pkg::OUT_CH1_CONTROL + 4'h1)
      begin
        nxt_ctrl_wr[1] = 1'b1;
      end
      // Stage bit sits in the lower control byte
      if (out_addr == dcp_pkg::OUT_CH0_CONTROL)
      begin
        nxt_ctrl_wr[0] = 1'b1;
      end
      if (out_addr == dcp_pkg::OUT_CH1_CONTROL)
      begin
        nxt_ctrl_wr[1] = 1'b1;
      end
    end
    // A channel takes its high time only when the top byte lands, so a word
    // rewritten byte by byte never runs with a half-old count
    nxt_ht[0] = ht_ff[0];
    nxt_ht[1] = ht_ff[1];
    if (out_wr && (out_addr == dcp_pkg::OUT_CH0_HIGH_TIME + 4'h3))
    begin
      nxt_ht[0] = {nxt_img[dcp_pkg::OUT_CH0_HIGH_TIME + 4'h3],
                   nxt_img[dcp_pkg::OUT_CH0_HIGH_TIME + 4'h2],
                   nxt_img[dcp_pkg::OUT_CH0_HIGH_TIME + 4'h1],
                   nxt_img[dcp_pkg::OUT_CH0_HIGH_TIME]};
    end
    if (out_wr && (out_addr == dcp_pkg::OUT_CH1_HIGH_TIME + 4'h3))
    begin
      nxt_ht[1] = {nxt_img[dcp_pkg::OUT_CH1_HIGH_TIME + 4'h3],
                   nxt_img[dcp_pkg::OUT_CH1_HIGH_TIME + 4'h2],
                   nxt_img[dcp_pkg::OUT_CH1_HIGH_TIME + 4'h1],
                   nxt_img[dcp_pkg::OUT_CH1_HIGH_TIME]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < IMG_BYTES; i++)
      begin
        img_ff[i] <= dcp_pkg::IMG_BYTE_RST;
      end
      for (int c = 0; c < dcp_pkg::NUM_CH; c++)
      begin
        ht_ff[c] <= 32'h0000_0000;
      end
      ctrl_wr_ff <= 2'h0;
    end
    else if (clk_en)
    begin
      for (int i = 0; i < IMG_BYTES; i++)
      begin
        img_ff[i] <= nxt_img[i];
      end
      for (int c = 0; c < dcp_pkg::NUM_CH; c++)
      begin
        ht_ff[c] <= nxt_ht[c];
      end
      ctrl_wr_ff <= nxt_ctrl_wr;
    end
  end

  // Channel image fields, little endian within each word
  assign ch_if[0].high_time = ht_ff[0];
  assign ch_if[1].high_time = ht_ff[1];
  assign ch_if[0].control = {img_ff[dcp_pkg::OUT_CH0_CONTROL + 4'h1], img_ff[dcp_pkg::OUT_CH0_CONTROL]};
  assign ch_if[1].control = {img_ff[dcp_pkg::OUT_CH1_CONTROL + 4'h1], img_ff[dcp_pkg::OUT_CH1_CONTROL]};

  genvar g;
  generate
    for (g = 0; g < dcp_pkg::NUM_CH; g++)
    begin : gen_ch
      assign ch_if[g].ctrl_wr = ctrl_wr_ff[g];
      dcp_channel #(
        .PERIOD_TICKS(PERIOD_TICKS)
      ) u_chan (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .ch(ch_if[g])
      );
      assign ch_running[g] = ch_if[g].running;
      assign ch_stage_hs[g] = ch_if[g].stage_hs;
      assign pwm_out[g] = ch_if[g].level;
      assign pwm_oe[g] = ch_if[g].drive_en;
    end
  endgenerate

  // One process builds both status words, so the array has a single driver
  always_comb
  begin
    for (int i = 0; i < dcp_pkg::NUM_CH; i++)
    begin
      sts_word[i] = 16'h0000;
      sts_word[i][dcp_pkg::STS_RUN_BIT] = ch_running[i];
      sts_word[i][dcp_pkg::STS_STAGE_BIT] = ch_stage_hs[i];
    end
  end

  // Input area read, registered
  always_comb
  begin
    case (in_addr)
      dcp_pkg::IN_CH0_STATUS: nxt_rdata = sts_word[0][7:0];
      dcp_pkg::IN_CH0_STATUS + 2'h1: nxt_rdata = sts_word[0][15:8];
      dcp_pkg::IN_CH1_STATUS: nxt_rdata = sts_word[1][7:0];
      dcp_pkg::IN_CH1_STATUS + 2'h1: nxt_rdata = sts_word[1][15:8];
      default: nxt_rdata = dcp_pkg::RDATA_RST;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_ff <= dcp_pkg::RDATA_RST;
    end
    else if (clk_en)
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign in_rdata = rdata_ff;

  // Indicators; a dead bus supply means the indicators have no power
  always_comb
  begin
    any_fault = overload_det || short_det || overheat_det;
    nxt_fault_led = any_fault && bus_power_ok;
    nxt_run_led = bus_comm_ok && bus_power_ok;
    for (int i = 0; i < dcp_pkg::NUM_CH; i++)
    begin
      nxt_led[i] = pwm_out[i] && bus_comm_ok && bus_power_ok && !any_fault;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      led_ff <= 2'h0;
      run_led_ff <= 1'b0;
      fault_led_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      led_ff <= nxt_led;
      run_led_ff <= nxt_run_led;
      fault_led_ff <= nxt_fault_led;
    end
  end

  assign chan_led = led_ff;
  assign run_led = run_led_ff;
  assign module_fault_indicator = fault_led_ff;

endmodule

// [tb/dcp_coupler_model.sv]
`timescale 1ns/1ps
module dcp_coupler_model (
  input wire logic ref_clk, // clock
  output logic out_wr, // write strobe
  output logic [3:0] out_addr, // write address
  output logic [7:0] out_wdata, // write byte
  output logic [1:0] in_addr, // read address
  input wire logic [7:0] in_rdata // read byte
);
  initial
  begin
    out_wr = 1'b0;
    out_addr = 4'h0;
    out_wdata = 8'h00;
    in_addr = 2'h0;
  end
  task automatic put(input logic [3:0] a, input logic [7:0] b);
    @(posedge ref_clk);
    out_wr <= 1'b1;
    out_addr <= a;
    out_wdata <= b;
  endtask
  // Released data toggles so a stale byte never looks valid
  task automatic idle();
    @(posedge ref_clk);
    out_wr <= 1'b0;
    out_wdata <= ~out_wdata;
  endtask
  task automatic wr_ht(input int ch, input logic [31:0] t);
    for (int i = 0; i < 4; i++)
      put(4'(4 * ch + i), t[8 * i +: 8]);
    idle();
  endtask
  task automatic wr_ctl(input int ch, input logic [15:0] c);
    put(4'(8 + 2 * ch), c[7:0]);
    put(4'(9 + 2 * ch), c[15:8]);
    idle();
  endtask
  task automatic rd_sts(input int ch, output logic [15:0] s);
    @(posedge ref_clk);
    in_addr <= 2'(2 * ch);
    @(posedge ref_clk);
    in_addr <= 2'(2 * ch + 1);
    #1 s[7:0] = in_rdata;
    @(posedge ref_clk);
    #1 s[15:8] = in_rdata;
  endtask
endmodule

// [tb/dcp_pwm_props.sv]
`timescale 1ns/1ps
module dcp_pwm_props (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  input wire logic clk_en, // enable
  input wire logic out_wr, // write
  input wire logic [3:0] out_addr, // address
  input wire logic [7:0] out_wdata, // data
  input wire logic [1:0] in_addr, // read address
  input wire logic [7:0] in_rdata, // read byte
  input wire logic bus_comm_ok, // comm
  input wire logic bus_power_ok, // power
  input wire logic overload_det, // fault
  input wire logic short_det, // fault
  input wire logic overheat_det, // fault
  input wire logic [1:0] pwm_out, // level
  input wire logic [1:0] pwm_oe, // enable
  input wire logic [1:0] chan_led, // leds
  input wire logic run_led, // run led
  input wire logic module_fault_indicator // fault led
);
  logic [2:0] up_ff;
  logic [1:0] hb0_ff;
  logic run0_ff;
  logic [1:0] stg_ff;
  wire ok = up_ff[2] && clk_en;
  wire flt = overload_det || short_det || overheat_det;
  // Skip the first edges after reset so a synchronised release can settle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_ff <= 3'h0;
      hb0_ff <= 2'h0;
      run0_ff <= 1'b0;
      stg_ff <= 2'h0;
    end
    else
    begin
      up_ff <= {up_ff[1:0], 1'b1};
      // Reference run state of channel 0, stop winning over start
      if (out_wr && clk_en && out_addr == 4'h9)
      begin
        hb0_ff <= out_wdata[1:0];
        if (out_wdata[1] && !hb0_ff[1])
          run0_ff <= 1'b0;
        else if (out_wdata[0] && !hb0_ff[0])
          run0_ff <= 1'b1;
      end
      if (out_wr && clk_en && out_addr == 4'h8)
        stg_ff[0] <= out_wdata[2];
      if (out_wr && clk_en && out_addr == 4'ha)
        stg_ff[1] <= out_wdata[2];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence start0_s;
    ok && out_wr && out_addr == 4'h9 && out_wdata[1:0] == 2'h1 && !hb0_ff[0] && !run0_ff;
  endsequence
  sequence stop0_s;
    ok && out_wr && out_addr == 4'h9 && out_wdata[1] && !hb0_ff[1];
  endsequence
  a_run_led_bus: assert property (ok |-> run_led == $past(bus_comm_ok && bus_power_ok))
    else $error("run led wrong");
  a_fault_led_any: assert property (ok |-> module_fault_indicator == $past(flt && bus_power_ok))
    else $error("fault led wrong");
  a_power_dark: assert property (ok && !$past(bus_power_ok) |-> !run_led && !module_fault_indicator)
    else $error("leds lit without power");
  a_chan_led_level: assert property (ok |-> chan_led == $past(pwm_out & {2{bus_comm_ok && bus_power_ok && !flt}}))
    else $error("channel led wrong");
  a_oe_high_drive: assert property (ok |-> (pwm_oe & pwm_out) == pwm_out)
    else $error("high level not driven");
  a_oe_stage_mode: assert property (ok && stg_ff == $past(stg_ff) |-> pwm_oe == ((pwm_out & stg_ff) | ~stg_ff))
    else $error("output enable does not follow stage");
  a_start_edge_run: assert property (start0_s |-> ##[2:3] pwm_out[0])
    else $error("start edge ignored");
  a_stop_edge_low: assert property (stop0_s |-> ##3 (!pwm_out[0]) [*5])
    else $error("stop edge ignored");
  a_rdata_high_zero: assert property (ok && $past(in_addr[0]) |-> in_rdata == 8'h00)
    else $error("status high byte not zero");
  a_rdata_resv_zero: assert property (ok |-> (in_rdata & 8'hf9) == 8'h00)
    else $error("reserved status bits set");
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, rst_n, clk_en, out_wr, bus_comm_ok, bus_power_ok;
  logic overload_det, short_det, overheat_det, run_led, module_fault_indicator;
  logic [3:0] out_addr;
  logic [7:0] out_wdata, in_rdata;
  logic [1:0] in_addr, pwm_out, pwm_oe, chan_led, lvl;
  logic [15:0] sts;
  int bad_count, check_count, n;
  dcp_pwm #(.PERIOD_TICKS(100)) dut_u (.ref_clk, .rst_n, .clk_en, .out_wr, .out_addr, .out_wdata, .in_addr,
    .in_rdata, .bus_comm_ok, .bus_power_ok, .overload_det, .short_det, .overheat_det, .pwm_out, .pwm_oe,
    .chan_led, .run_led, .module_fault_indicator);
  dcp_coupler_model model_u (.ref_clk, .out_wr, .out_addr, .out_wdata, .in_addr, .in_rdata);
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic int hi_cycles(input int t);
    return (t * dcp_pkg::TICK_SCALE + dcp_pkg::TICK_STEP - 1) / dcp_pkg::TICK_STEP;
  endfunction
  // Length of one whole high pulse; 0 when none shows
  task automatic meas(input int ch, output int len);
    len = 0;
    for (int i = 0; i < 300 && pwm_out[ch] !== 1'b0; i++)
      @(negedge ref_clk);
    for (int i = 0; i < 300 && pwm_out[ch] !== 1'b1; i++)
      @(negedge ref_clk);
    while (pwm_out[ch] === 1'b1 && len < 300)
    begin
      len++;
      @(negedge ref_clk);
    end
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever
      #12.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (20000)
      @(posedge ref_clk);
    bad_count++;
    wrap_up();
  end
  initial
  begin
    {bad_count, check_count} = '0;
    {rst_n, overload_det, short_det, overheat_det} = '0;
    {clk_en, bus_comm_ok, bus_power_ok} = 3'h7;
    repeat (8)
      @(posedge ref_clk);
    rst_n <= 1'b1;
    model_u.rd_sts(0, sts);
    chk(sts, 16'h0000);
    model_u.wr_ht(0, 32'd60);
    model_u.wr_ht(1, 32'd48);
    model_u.put(4'hc, 8'hff);
    model_u.wr_ctl(0, 16'h0100);
    model_u.wr_ctl(1, 16'h0104);
    model_u.rd_sts(0, sts);
    chk(sts, 16'h0002);
    model_u.rd_sts(1, sts);
    chk(sts, 16'h0006);
    meas(0, n);
    chk(16'(n), 16'(hi_cycles(60)));
    meas(1, n);
    chk(16'(n), 16'(hi_cycles(48)));
    chk({14'h0, pwm_oe}, 16'h0001);
    model_u.wr_ctl(0, 16'h0300);
    model_u.rd_sts(0, sts);
    chk(sts, 16'h0000);
    meas(0, n);
    chk(16'(n), 16'h0000);
    model_u.wr_ctl(0, 16'h0100);
    model_u.rd_sts(0, sts);
    chk(sts, 16'h0000);
    model_u.wr_ctl(0, 16'h0000);
    model_u.wr_ctl(0, 16'h0100);
    model_u.rd_sts(0, sts);
    chk(sts, 16'h0002);
    model_u.wr_ctl(1, 16'h0100);
    model_u.rd_sts(1, sts);
    chk(sts, 16'h0002);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge ref_clk);
      bus_comm_ok <= i[0];
      bus_power_ok <= i[1];
      overload_det <= i[3:2] == 2'h1;
      short_det <= i[3:2] == 2'h2;
      overheat_det <= i[3:2] == 2'h3;
      repeat (2)
        @(negedge ref_clk);
      lvl = pwm_out;
      @(negedge ref_clk);
      chk(16'(chan_led), 16'(lvl & {2{i[0] & i[1] & (i[3:2] == 2'h0)}}));
      chk(16'(run_led), 16'(i[0] & i[1]));
      chk(16'(module_fault_indicator), 16'(i[3:2] != 2'h0 && i[1]));
    end
    wrap_up();
  end
endmodule
bind dcp_pwm dcp_pwm_props chk_u (.ref_clk, .rst_n, .clk_en, .out_wr, .out_addr, .out_wdata, .in_addr,
  .in_rdata, .bus_comm_ok, .bus_power_ok, .overload_det, .short_det, .overheat_det, .pwm_out, .pwm_oe,
  .chan_led, .run_led, .module_fault_indicator);
